// *** design/swsc_device.sv ***
// Stabilization wait controller: standby states, wait counter and status
`timescale 1ns/1ps
`default_nettype none

module swsc_device
	import swsc_pkg::*;
#(
	parameter int SCALE_SHIFT = 0,
	parameter int RST_MIN_CYC = RST_MIN_CYC_DEF
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link to the CPU side
	swsc_link_if.dev lnk,
	// Option setting: high-speed clock is an external RC oscillator
	input wire logic opt_rc_osc,
	// Local view of the controller
	output logic cpu_run_view,
	output logic [NLVL-1:0] status_view
);

	localparam int RC_W = $clog2(RST_MIN_CYC + 1);
	localparam logic [RC_W-1:0] RC_LAST = RC_W'(RST_MIN_CYC);

	// Threshold in clocks for status bit idx, shortened by SCALE_SHIFT
	function automatic logic [CNT_W-1:0] thr_of(input int idx);
		logic [CNT_W-1:0] one;
		one = CNT_W'(1);
		return one << (STAB_EXP[idx] - SCALE_SHIFT);
	endfunction

	// Only codes that name a real wait length are accepted
	function automatic logic sel_ok(input logic [SEL_W-1:0] code);
		return (code >= SEL_MIN) && (code <= SEL_MAX);
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Synchronisers for the reset pin and the oscillator-running level

	logic rpin_s1_r;
	logic rpin_s2_r;
	logic osc_s1_r;
	logic osc_s2_r;

	// Pin and oscillator come from outside the clock's timing
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			rpin_s1_r <= 1'b1;
			rpin_s2_r <= 1'b1;
			osc_s1_r <= 1'b0;
			osc_s2_r <= 1'b0;
		end else begin
			rpin_s1_r <= lnk.reset_pin_n;
			rpin_s2_r <= rpin_s1_r;
			osc_s1_r <= lnk.osc_running;
			osc_s2_r <= osc_s1_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reset pin qualifier

	logic [RC_W-1:0] low_cnt_r;
	logic [RC_W-1:0] low_cnt_nxt;
	logic rst_hold;

	// Count low clocks; short glitches never reach the last count
	always_comb begin
		if (rpin_s2_r)
			low_cnt_nxt = '0;
		else if (low_cnt_r != RC_LAST)
			low_cnt_nxt = low_cnt_r + 1'b1;
		else
			low_cnt_nxt = low_cnt_r;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			low_cnt_r <= '0;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	// Reset is held from recognition until the pin goes high again
	assign rst_hold = (low_cnt_r == RC_LAST);

	////////////////////////////////////////////////////////////////////////
	// Threshold compare, one per status bit

	logic [SEL_W-1:0] sel_r;
	logic [CNT_W-1:0] cnt_r;
	logic [NLVL-1:0] hit;
	logic wait_done;

	// A bit beyond the selected length never sets
	genvar g;
	generate
		for (g = 0; g < NLVL; g++) begin : g_thr
			assign hit[g] = (SEL_W'(g) < sel_r)
				&& (cnt_r >= thr_of(g));
		end
	endgenerate

	// The last selected threshold ends the wait
	assign wait_done = hit[sel_r - SEL_MIN];

	////////////////////////////////////////////////////////////////////////
	// Standby state, wait counter, status and select

	swsc_state_t st_r;
	swsc_state_t st_nxt;
	logic [CNT_W-1:0] cnt_nxt;
	logic [NLVL-1:0] sts_r;
	logic [NLVL-1:0] sts_nxt;
	logic [SEL_W-1:0] sel_nxt;

	always_comb begin
		st_nxt = st_r;
		cnt_nxt = cnt_r;
		sts_nxt = sts_r;
		sel_nxt = sel_r;
		if (rst_hold) begin
			// Pin reset also puts the select back to its longest wait
			st_nxt = ST_RESET;
			cnt_nxt = '0;
			sts_nxt = '0;
			sel_nxt = SEL_RESET;
		end else begin
			case (st_r)
				ST_RUN: begin
					// Bad codes are dropped so the wait length stays legal
					if (lnk.sel_wr && sel_ok(lnk.sel_data))
						sel_nxt = lnk.sel_data;
					if (lnk.stop_req) begin
						cnt_nxt = '0;
						sts_nxt = '0;
						if (lnk.int_pend)
							st_nxt = ST_HALT;
						else
							st_nxt = ST_STOP;
					end
				end
				ST_STOP: begin // Let a stale oscillator level drain first
					if (lnk.int_pend && !osc_s2_r)
						st_nxt = ST_OSCW;
				end
				ST_RESET: begin
					st_nxt = ST_OSCW;
				end
				ST_OSCW: begin
					// Counting waits for the oscillator, not for the release
					if (osc_s2_r) begin
						cnt_nxt = '0;
						sts_nxt = '0;
						if (opt_rc_osc)
							st_nxt = ST_RUN;
						else
							st_nxt = ST_STAB;
					end
				end
				ST_STAB, ST_HALT: begin
					sts_nxt = sts_r | hit;
					if (opt_rc_osc) begin
						st_nxt = ST_RUN;
					end else if (wait_done) begin
						st_nxt = ST_RUN;
					end else begin
						cnt_nxt = CNT_W'(cnt_r + 1'b1);
					end
				end
				default: begin
					st_nxt = ST_RUN;
				end
			endcase
		end
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			st_r <= ST_RUN;
			cnt_r <= '0;
			sts_r <= '0;
			sel_r <= SEL_RESET;
		end else begin
			st_r <= st_nxt;
			cnt_r <= cnt_nxt;
			sts_r <= sts_nxt;
			sel_r <= sel_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Registered outputs, decoded from the next state

	logic osc_en_r;
	logic osc_en_nxt;
	logic cpu_run_r;
	logic cpu_run_nxt;
	logic halt_r;
	logic halt_nxt;
	logic stop_r;
	logic stop_nxt;
	logic rsto_r;
	logic rsto_nxt;

	// Oscillators rest in stop and under a held reset pin
	always_comb begin
		osc_en_nxt = (st_nxt != ST_STOP) && (st_nxt != ST_RESET);
		cpu_run_nxt = (st_nxt == ST_RUN);
		halt_nxt = (st_nxt == ST_HALT);
		stop_nxt = (st_nxt == ST_STOP) || (st_nxt == ST_OSCW)
			|| (st_nxt == ST_STAB);
		rsto_nxt = (st_nxt == ST_RESET);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			osc_en_r <= 1'b1;
			cpu_run_r <= 1'b1;
			halt_r <= 1'b0;
			stop_r <= 1'b0;
			rsto_r <= 1'b0;
		end else begin
			osc_en_r <= osc_en_nxt;
			cpu_run_r <= cpu_run_nxt;
			halt_r <= halt_nxt;
			stop_r <= stop_nxt;
			rsto_r <= rsto_nxt;
		end
	end

	// Link outputs straight from flip-flops
	assign lnk.osc_en = osc_en_r;
	assign lnk.cpu_run = cpu_run_r;
	assign lnk.halt_st = halt_r;
	assign lnk.stop_st = stop_r;
	assign lnk.in_reset = rsto_r;
	assign lnk.stab_status = sts_r;
	assign lnk.sel_q = sel_r;
	assign cpu_run_view = cpu_run_r;
	assign status_view = sts_r;

endmodule
`default_nettype wire

// *** design/swsc_host.sv ***
// CPU, interrupt controller and oscillator end of the stabilization link
`timescale 1ns/1ps
`default_nettype none
module swsc_host
	import swsc_pkg::*;
#(
	parameter int NIRQ = 4,
	parameter int RST_MIN_CYC = RST_MIN_CYC_DEF,
	parameter int OSC_START_CYC = OSC_START_CYC_DEF
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Link to the stabilization controller
	swsc_link_if.host lnk,
	// Software commands
	input wire logic cmd_stop,
	input wire logic cmd_sel_wr,
	input wire logic [SEL_W-1:0] cmd_sel,
	input wire logic cmd_ext_reset,
	// Interrupt request and mask flags
	input wire logic [NIRQ-1:0] irq_req,
	input wire logic [NIRQ-1:0] irq_mask,
	// Command progress
	output logic stop_busy,
	output logic sel_busy,
	output logic rst_busy
);

	localparam int RH = RST_MIN_CYC + RST_MARGIN_CYC;
	localparam int RH_W = $clog2(RH + 1);
	localparam int OC_W = $clog2(OSC_START_CYC + 1);
	localparam logic [RH_W-1:0] RH_CNT = RH_W'(RH);
	localparam logic [OC_W-1:0] OC_CNT = OC_W'(OSC_START_CYC);

	////////////////////////////////////////////////////////////////////////
	// Command queue, reset pulse and oscillator model

	logic stop_pend_r;
	logic stop_pend_nxt;
	logic sel_pend_r;
	logic sel_pend_nxt;
	logic [SEL_W-1:0] sel_val_r;
	logic [SEL_W-1:0] sel_val_nxt;
	logic stop_req_r;
	logic stop_req_nxt;
	logic sel_wr_r;
	logic sel_wr_nxt;
	logic int_pend_r;
	logic int_pend_nxt;
	logic [RH_W-1:0] rcnt_r;
	logic [RH_W-1:0] rcnt_nxt;
	logic pin_n_r;
	logic pin_n_nxt;
	logic [OC_W-1:0] ocnt_r;
	logic [OC_W-1:0] ocnt_nxt;
	logic osc_r;
	logic osc_nxt;
	logic done_ok;

	// Status bit of the current wait; never beyond the selected length
	assign done_ok = (lnk.sel_q >= SEL_MIN)
		&& lnk.stab_status[lnk.sel_q - SEL_MIN];

	always_comb begin
		stop_pend_nxt = stop_pend_r | cmd_stop;
		sel_pend_nxt = sel_pend_r | cmd_sel_wr;
		sel_val_nxt = cmd_sel_wr ? cmd_sel : sel_val_r;
		stop_req_nxt = 1'b0;
		sel_wr_nxt = 1'b0;
		int_pend_nxt = |(irq_req & ~irq_mask);
		// Select goes first, and only once the last wait is seen complete
		if (sel_pend_r && lnk.cpu_run && done_ok && !sel_wr_r) begin
			sel_wr_nxt = 1'b1;
			sel_pend_nxt = cmd_sel_wr;
		end else if (stop_pend_r && !sel_pend_r && !sel_wr_r
				&& lnk.cpu_run && !stop_req_r) begin
			stop_req_nxt = 1'b1;
			stop_pend_nxt = cmd_stop;
		end
		// Pin held low a little past the least recognised time
		if (cmd_ext_reset && pin_n_r)
			rcnt_nxt = RH_CNT;
		else if (rcnt_r != '0)
			rcnt_nxt = rcnt_r - 1'b1;
		else
			rcnt_nxt = rcnt_r;
		pin_n_nxt = (rcnt_nxt == '0);
		// Oscillation begins a fixed time after enable
		if (!lnk.osc_en)
			ocnt_nxt = '0;
		else if (ocnt_r != OC_CNT)
			ocnt_nxt = ocnt_r + 1'b1;
		else
			ocnt_nxt = ocnt_r;
		osc_nxt = lnk.osc_en && (ocnt_r == OC_CNT);
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			stop_pend_r <= 1'b0;
			sel_pend_r <= 1'b0;
			sel_val_r <= SEL_RESET;
			stop_req_r <= 1'b0;
			sel_wr_r <= 1'b0;
			int_pend_r <= 1'b0;
			rcnt_r <= '0;
			pin_n_r <= 1'b1;
			ocnt_r <= '0;
			osc_r <= 1'b0;
		end else begin
			stop_pend_r <= stop_pend_nxt;
			sel_pend_r <= sel_pend_nxt;
			sel_val_r <= sel_val_nxt;
			stop_req_r <= stop_req_nxt;
			sel_wr_r <= sel_wr_nxt;
			int_pend_r <= int_pend_nxt;
			rcnt_r <= rcnt_nxt;
			pin_n_r <= pin_n_nxt;
			ocnt_r <= ocnt_nxt;
			osc_r <= osc_nxt;
		end
	end

	// Link and progress outputs straight from flip-flops
	assign lnk.stop_req = stop_req_r;
	assign lnk.sel_wr = sel_wr_r;
	assign lnk.sel_data = sel_val_r;
	assign lnk.int_pend = int_pend_r;
	assign lnk.reset_pin_n = pin_n_r;
	assign lnk.osc_running = osc_r;
	assign stop_busy = stop_pend_r;
	assign sel_busy = sel_pend_r;
	assign rst_busy = !pin_n_r;

endmodule
`default_nettype wire

// *** shared/swsc_link_if.sv ***
// Link between the stabilization controller and the CPU/interrupt/oscillator end
`timescale 1ns/1ps
`default_nettype none
interface swsc_link_if;
	import swsc_pkg::*;

	// Driven by the CPU, interrupt controller and oscillator end
	logic stop_req;
	logic sel_wr;
	logic [SEL_W-1:0] sel_data;
	logic int_pend;
	logic reset_pin_n;
	logic osc_running;

	// Driven by the stabilization controller
	logic osc_en;
	logic cpu_run;
	logic halt_st;
	logic stop_st;
	logic in_reset;
	logic [NLVL-1:0] stab_status;
	logic [SEL_W-1:0] sel_q;

	modport dev (
		input stop_req, sel_wr, sel_data, int_pend, reset_pin_n, osc_running,
		output osc_en, cpu_run, halt_st, stop_st, in_reset, stab_status, sel_q
	);

	modport host (
		output stop_req, sel_wr, sel_data, int_pend, reset_pin_n, osc_running,
		input osc_en, cpu_run, halt_st, stop_st, in_reset, stab_status, sel_q
	);
endinterface
`default_nettype wire

// *** shared/swsc_pkg.sv ***
// Constants and types shared by both ends of the stop-wake stabilization link
package swsc_pkg;

	// Clock period of sys_clk, in picoseconds
	localparam int CLK_PERIOD_PS = 40000;

	// Wait select field: codes 1..NLVL pick a stabilization length
	localparam int SEL_W = 3;
	localparam int NLVL = 5;
	localparam logic [SEL_W-1:0] SEL_MIN = 3'h1;
	localparam logic [SEL_W-1:0] SEL_MAX = 3'h5;
	localparam logic [SEL_W-1:0] SEL_RESET = 3'h5;

	// Threshold exponents: status bit i sets after 2**STAB_EXP[i] clocks
	localparam int STAB_EXP [NLVL] = '{11, 13, 14, 15, 16};
	localparam int CNT_W = 17;

	// Least low time on the reset pin, and its count in clocks (rounded up)
	localparam int RST_MIN_NS = 10000;
	localparam int RST_MIN_CYC_DEF =
		(RST_MIN_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	// Extra low clocks the host adds beyond the least time
	localparam int RST_MARGIN_CYC = 4;

	// Oscillator start delay modelled by the host (longest time, rounded down)
	localparam int OSC_START_NS = 1000;
	localparam int OSC_START_CYC_DEF =
		(OSC_START_NS * 1000) / CLK_PERIOD_PS;

	// Standby states, Gray coded along run-stop-wake-count-run
	typedef enum logic [2:0] {
		ST_RUN = 3'h0,
		ST_STOP = 3'h1,
		ST_OSCW = 3'h3,
		ST_STAB = 3'h2,
		ST_HALT = 3'h6,
		ST_RESET = 3'h4
	} swsc_state_t;

endpackage

// *** sim/swsc_sva.sv ***
// Timing checks on the stop-wake stabilization link between the two ends
`timescale 1ns/1ps
`default_nettype none
module swsc_sva
	import swsc_pkg::*;
#(
	parameter int RST_MIN_CYC = RST_MIN_CYC_DEF
)(
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Host to device
	input wire logic stop_req,
	input wire logic sel_wr,
	input wire logic [SEL_W-1:0] sel_data,
	input wire logic int_pend,
	input wire logic reset_pin_n,
	input wire logic osc_running,
	// Device to host
	input wire logic osc_en,
	input wire logic cpu_run,
	input wire logic halt_st,
	input wire logic stop_st,
	input wire logic in_reset,
	input wire logic [NLVL-1:0] stab_status,
	input wire logic [SEL_W-1:0] sel_q
);
	logic [8:0] low_cnt_r;
	logic [8:0] low_cnt_nxt;

	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rst_n);

	////////////////////////////////////////////////////////////////////////
	// Low time of the reset pin, saturating so long holds never wrap
	always_comb begin
		low_cnt_nxt = low_cnt_r;
		if (reset_pin_n)
			low_cnt_nxt = 9'h0;
		else if (low_cnt_r != 9'h1ff)
			low_cnt_nxt = low_cnt_r + 9'h1;
	end

	// Register only
	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n)
			low_cnt_r <= 9'h0;
		else
			low_cnt_r <= low_cnt_nxt;
	end

	////////////////////////////////////////////////////////////////////////
	// Status fills from bit 0 without gaps
	a_status_ordered: assert property (
		((stab_status + 5'h1) & stab_status) == 5'h0)
		else $error("status bits not filled in order");
	a_status_sticky: assert property (
		cpu_run && $past(cpu_run) |-> $stable(stab_status))
		else $error("status changed while running");
	a_status_in_sel: assert property (
		stop_st |-> (stab_status >> sel_q) == 5'h0)
		else $error("status bit beyond selected wait");
	a_clear_entry: assert property (
		($rose(stop_st) || $rose(halt_st)) |-> stab_status == 5'h0)
		else $error("status not cleared on standby entry");
	a_stop_entry: assert property (
		stop_req && cpu_run && !int_pend
		|=> stop_st && !osc_en && !cpu_run)
		else $error("stop not entered");
	a_halt_entry: assert property (
		stop_req && cpu_run && int_pend |=> halt_st && !stop_st)
		else $error("pending request did not turn stop into halt");
	a_halt_wait: assert property (
		$rose(halt_st) |-> !cpu_run [*6] ##[1:300] cpu_run)
		else $error("halt wait length wrong");
	a_reset_osc_off: assert property (
		in_reset |-> !osc_en && !cpu_run)
		else $error("oscillators running in reset");
	a_reset_len: assert property (
		$rose(in_reset) |-> low_cnt_r >= RST_MIN_CYC)
		else $error("short reset pulse recognised");
	a_osc_first: assert property (
		$rose(stab_status[0]) |-> osc_running && $past(osc_running, 4))
		else $error("count began before oscillation");
	a_sel_take: assert property (
		sel_wr && cpu_run && sel_data >= SEL_MIN && sel_data <= SEL_MAX
		|=> sel_q == $past(sel_data))
		else $error("select write not taken");

	// Main scenarios reached
	c_halt: cover property ($rose(halt_st));
	c_reset: cover property ($rose(in_reset));
	c_full: cover property ($rose(stab_status[4]));
endmodule
`default_nettype wire

// *** sim/tb_stop_wake_stabilization_control.sv ***
// Self-checking bench joining both ends of the stabilization link
`timescale 1ns/1ps
`default_nettype none
module tb_stop_wake_stabilization_control;
	import swsc_pkg::*;
	logic sys_clk, rst_n, cmd_stop, cmd_sel_wr, cmd_ext_reset, opt_rc;
	logic [2:0] cmd_sel;
	logic [3:0] irq_req, irq_mask;
	logic stop_busy, sel_busy, rst_busy, cpu_run_v;
	logic [4:0] status_v;
	int mismatches, total_checks, i;
	logic [2:0] v;

	swsc_link_if lnk();
	// Short thresholds 8..256 clocks keep the run brief
	swsc_device #(.SCALE_SHIFT(8), .RST_MIN_CYC(10)) i_swsc_device (
		.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk), .opt_rc_osc(opt_rc),
		.cpu_run_view(cpu_run_v), .status_view(status_v));
	swsc_host #(.RST_MIN_CYC(10), .OSC_START_CYC(3)) i_swsc_host (
		.sys_clk(sys_clk), .rst_n(rst_n), .lnk(lnk), .cmd_stop(cmd_stop),
		.cmd_sel_wr(cmd_sel_wr), .cmd_sel(cmd_sel),
		.cmd_ext_reset(cmd_ext_reset), .irq_req(irq_req), .irq_mask(irq_mask),
		.stop_busy(stop_busy), .sel_busy(sel_busy), .rst_busy(rst_busy));
	swsc_sva #(.RST_MIN_CYC(10)) i_swsc_sva (.sys_clk(sys_clk), .rst_n(rst_n),
		.stop_req(lnk.stop_req), .sel_wr(lnk.sel_wr), .sel_data(lnk.sel_data),
		.int_pend(lnk.int_pend), .reset_pin_n(lnk.reset_pin_n),
		.osc_running(lnk.osc_running), .osc_en(lnk.osc_en),
		.cpu_run(lnk.cpu_run), .halt_st(lnk.halt_st), .stop_st(lnk.stop_st),
		.in_reset(lnk.in_reset), .stab_status(lnk.stab_status),
		.sel_q(lnk.sel_q));

	////////////////////////////////////////////////////////////////////////
	// Clock and watchdog
	always #20 sys_clk = ~sys_clk;
	initial begin
		#2000000;
		mismatches++;
		end_sim();
	end

	// Verdict and end of run
	task automatic end_sim();
		if (mismatches == 0 && total_checks > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask

	// Bits expected once a full wait for select v has run
	function automatic logic [4:0] exp_st(input logic [2:0] v);
		exp_st = 5'h1f >> (3'h5 - v);
	endfunction

	// Bounded wait for run state to reach want with nothing queued
	task automatic wt(input logic want);
		int n;
		n = 0;
		while (!(cpu_run_v === want && stop_busy === 1'b0 &&
			sel_busy === 1'b0 && rst_busy === 1'b0) && n < 4000) begin
			@(negedge sys_clk);
			n++;
		end
		if (n >= 4000)
			mismatches++;
	endtask

	// Select write; the answer lands one cycle after the link pulse
	task automatic sel(input logic [2:0] c);
		@(negedge sys_clk);
		cmd_sel = c;
		cmd_sel_wr = 1'b1;
		@(negedge sys_clk);
		cmd_sel_wr = 1'b0;
		wt(1'b1);
		repeat (2) @(negedge sys_clk);
	endtask

	// One standby round; a masked request must not block stop
	task automatic cyc(input logic [2:0] c, input logic halt, input logic rc);
		opt_rc = rc;
		irq_req = 4'h1 << $urandom_range(0, 3);
		irq_mask = halt ? 4'h0 : 4'hf;
		cmd_stop = 1'b1;
		@(negedge sys_clk);
		cmd_stop = 1'b0;
		wt(1'b0);
		chk(lnk.halt_st, halt);
		chk(lnk.stop_st, !halt);
		chk(status_v, 5'h0);
		repeat ($urandom_range(1, 20)) @(negedge sys_clk);
		irq_mask = 4'h0;
		wt(1'b1);
		chk(status_v, rc ? 5'h0 : exp_st(c));
		irq_req = 4'h0;
		opt_rc = 1'b0;
		@(negedge sys_clk);
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		sys_clk = 1'b0;
		rst_n = 1'b0;
		{cmd_stop, cmd_sel_wr, cmd_ext_reset, opt_rc} = 4'h0;
		cmd_sel = 3'h0;
		irq_req = 4'h0;
		irq_mask = 4'h0;
		mismatches = 0;
		total_checks = 0;
		void'($urandom(32'h3884fd7c));
		repeat (12) @(negedge sys_clk);
		rst_n = 1'b1;
		@(negedge sys_clk);
		chk(lnk.sel_q, SEL_RESET);
		chk(status_v, 5'h0);
		cyc(3'h5, 1'b0, 1'b0);
		chk(status_v, 5'h1f);
		// Boundary selects first, then random ones and halt or stop
		for (i = 0; i < 8; i++) begin
			v = (i == 0) ? 3'h1 : (i == 1) ? 3'h5 : 3'($urandom_range(1, 5));
			sel(v);
			chk(lnk.sel_q, v);
			cyc(v, (i > 1) ? 1'($urandom_range(0, 1)) : 1'b0, 1'b0);
		end
		// Unused codes leave the select alone
		sel(3'h0);
		chk(lnk.sel_q, v);
		sel(3'h7);
		chk(lnk.sel_q, v);
		// Pin reset stops oscillators, then a full default wait follows
		sel(3'h2);
		cmd_ext_reset = 1'b1;
		@(negedge sys_clk);
		cmd_ext_reset = 1'b0;
		i = 0;
		while (lnk.in_reset !== 1'b1 && i < 100) begin
			@(negedge sys_clk);
			i++;
		end
		chk(lnk.osc_en, 1'b0);
		chk(lnk.sel_q, SEL_RESET);
		wt(1'b1);
		chk(status_v, exp_st(3'h5));
		// RC option wakes with no count; kept last, as the empty status
		// it leaves holds off any later select write from the host
		cyc(3'h5, 1'b0, 1'b1);
		end_sim();
	end
endmodule
`default_nettype wire
